// file: core/ssp_core.sv
`timescale 1ns/1ps
// Functional notes
// RQ1: Clock, input and output pins; unused data pins are left undriven for general use.
// RQ2: Rate field picks one of six internal clocks driven out, or external clock.
// RQ3: Shift order bit selects MSB-first or LSB-first.
// RQ4: Edge select bit picks rising or falling edge to latch input.
// RQ5: Sample phase bit samples input mid-bit or at bit end.
// RQ6: Mode field selects transmit-only, receive-only or full duplex.
// RQ7: Transmit-only shifts the buffered byte out after start is set.
// RQ8: After the last bit the interrupt flag sets and start clears.
// RQ9: Software sets start again for each byte; one byte per start.
// RQ10: Transmit-only, internal clock: no start without fresh data written.
// RQ11: Receive-only shifts eight bits in, then interrupts and clears start.
// RQ12: Receive-only, internal clock: no start while previous byte unread.
// RQ13: Full duplex sends and captures one byte together.
// RQ14: One shared data buffer for transmit and receive.
// RQ15: Duplex, internal clock: write before read withholds transfer.
// RQ16: Slave select works only with external clock and when enabled.
// RQ17: Slave select high stops driving output and data is ignored.
// RQ18: Receive full sets on captured byte, clears on data read.
// RQ19: Write during shifting sets collision flag and is discarded.
// RQ20: Interrupt flag stays until cleared; request only when enabled.
module ssp_core (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe,
  input  wire logic       si_i,
  output logic            so_o,
  output logic            so_oe,
  input  wire logic       ss_n_i,
  output logic            irq
);
  ssp_pkg::ssp_cfg_t  cfg_q;
  ssp_pkg::ssp_pins_t pins;
  ssp_pkg::ssp_pins_t lvl;
  ssp_pkg::ssp_pins_t rise;
  ssp_pkg::ssp_pins_t fall;

  logic [7:0] data_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [3:0] lat_q;
  logic [4:0] hc_q;
  logic       busy_q;
  logic       start_q;
  logic       new_q;
  logic       wbr_q;
  logic       rbf_q;
  logic       write_collision_flag_q;
  logic       iflag_q;
  logic       ien_q;
  logic       sck_q;

  // Register port decode.
  wire        wr_a    = wr && (addr == ssp_pkg::SSP_OFS_CTRL_A);
  wire        wr_b    = wr && (addr == ssp_pkg::SSP_OFS_CTRL_B);
  wire        wr_d    = wr && (addr == ssp_pkg::SSP_OFS_DATA);
  wire        wr_o    = wr && (addr == ssp_pkg::SSP_OFS_OPT);
  wire        wr_i    = wr && (addr == ssp_pkg::SSP_OFS_IRQ);
  wire        rd_d    = rd && (addr == ssp_pkg::SSP_OFS_DATA);
  wire [7:0]  reg_a   = {cfg_q.sample_phase_select, write_collision_flag_q, cfg_q.rate, cfg_q.edge_sel, cfg_q.lsb_first, ~new_q};
  wire [7:0]  reg_b   = {start_q, 4'h0, cfg_q.mode, rbf_q};
  wire [7:0]  reg_o   = {6'h00, cfg_q.ss_en, cfg_q.ext_clk};
  wire [7:0]  reg_i   = {6'h00, ien_q, iflag_q};
  wire [7:0]  rd_mux  = (addr == ssp_pkg::SSP_OFS_CTRL_A) ? reg_a :
                        (addr == ssp_pkg::SSP_OFS_CTRL_B) ? reg_b :
                        (addr == ssp_pkg::SSP_OFS_DATA)   ? data_q :
                        (addr == ssp_pkg::SSP_OFS_OPT)    ? reg_o :
                        (addr == ssp_pkg::SSP_OFS_IRQ)    ? reg_i : 8'h00;

  // Mode decode.
  wire        m_tx    = (cfg_q.mode == ssp_pkg::SSP_MODE_TX);                                            // RQ6
  wire        m_rx    = (cfg_q.mode == ssp_pkg::SSP_MODE_RX);                                            // RQ6
  wire        m_dup   = !m_tx && !m_rx;                                                                  // RQ13
  wire        ext     = cfg_q.ext_clk;                                                                   // RQ2
  wire        ss_on   = ext && cfg_q.ss_en;                                                              // RQ16
  wire        desel   = ss_on && lvl.ss;                                                                 // RQ17

  // Start guards for the internal clock.
  wire        ok_tx   = new_q;                                                                           // RQ10
  wire        ok_rx   = !rbf_q;                                                                          // RQ12
  wire        ok_dup  = new_q && !rbf_q && !wbr_q;                                                       // RQ15
  wire        ok      = ext || (m_tx ? ok_tx : m_rx ? ok_rx : ok_dup);
  wire        go      = start_q && !busy_q && ok;                                                        // RQ9
  wire [7:0]  tx_src  = wr_d ? wdata : data_q;

  // Serial clock events, internal or external.
  wire        tick;
  wire        i_shift = !ext && busy_q && tick && !hc_q[0];
  wire        i_latch = !ext && busy_q && tick && hc_q[0];
  wire        e_rise  = ext && busy_q && !desel && rise.sck;
  wire        e_fall  = ext && busy_q && !desel && fall.sck;
  wire        e_latch = cfg_q.edge_sel ? e_fall : e_rise;                                                // RQ4
  wire        e_shift = cfg_q.edge_sel ? e_rise : e_fall;                                                // RQ4
  wire        latch   = i_latch || e_latch;
  wire        shift   = (i_shift || e_shift) && (lat_q != 4'h0);
  wire        last    = (lat_q == 4'(ssp_pkg::SSP_BITS - 1));
  wire        full    = (lat_q == 4'(ssp_pkg::SSP_BITS));
  // The external master gives no edge after the last latch, so end sampling closes there.
  wire        end_ph  = cfg_q.sample_phase_select && !(ext && last);                                                     // RQ5
  wire        smp_lat = latch && !end_ph;                                                                // RQ5
  wire        smp_sh  = shift && cfg_q.sample_phase_select;                                                              // RQ5
  wire        done    = (smp_lat && last) || (smp_sh && full);                                           // RQ8
  wire        sample  = (smp_lat || smp_sh) && !m_tx;                                                    // RQ11
  wire        advance = shift && !full;
  wire        si_bit  = lvl.si;
  wire [7:0]  rx_next = cfg_q.lsb_first ? {si_bit, rx_q[7:1]} : {rx_q[6:0], si_bit};                     // RQ3
  wire        tx_bit  = cfg_q.lsb_first ? tx_q[0] : tx_q[7];                                             // RQ3
  wire [7:0]  tx_next = cfg_q.lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
  wire        sck_idl = ~cfg_q.edge_sel;

  assign pins = '{sck: sck_i, si: si_i, ss: ss_n_i};

  ssp_sync #(
    .W       (3)
  ) u_sync (
    .clk     (clk),
    .nrst    (nrst),
    .pin_i   (pins),
    .level_q (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  ssp_rate_gen u_rate (
    .clk     (clk),
    .nrst    (nrst),
    .en      (busy_q && !ext),
    .rate    (cfg_q.rate),
    .tick    (tick)
  );

  // Configuration registers.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cfg_q <= '0;
    else
    begin
      if (wr_a)
      begin
        cfg_q.sample_phase_select       <= wdata[ssp_pkg::SSP_A_SMP];
        cfg_q.rate      <= wdata[ssp_pkg::SSP_A_RATE +: 3];                                              // RQ2
        cfg_q.edge_sel  <= wdata[ssp_pkg::SSP_A_EDGE];
        cfg_q.lsb_first <= wdata[ssp_pkg::SSP_A_ORD];
      end
      if (wr_b && !busy_q)
        cfg_q.mode      <= ssp_pkg::ssp_mode_t'(wdata[ssp_pkg::SSP_B_MODE +: 2]);
      if (wr_o && !busy_q)
      begin
        cfg_q.ext_clk   <= wdata[ssp_pkg::SSP_O_EXTCLK];
        cfg_q.ss_en     <= wdata[ssp_pkg::SSP_O_SSEN];
      end
    end
  end

  // Start bit, busy and the data buffer.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      start_q <= 1'b0;
      busy_q  <= 1'b0;
      data_q  <= ssp_pkg::SSP_RST_REG;
    end
    else
    begin
      if (done)
        start_q <= 1'b0;                                                                                 // RQ8
      else if (wr_b && !busy_q)
        start_q <= wdata[ssp_pkg::SSP_B_START];
      if (done)
        busy_q <= 1'b0;
      else if (go)
        busy_q <= 1'b1;                                                                                  // RQ7
      if (done && !m_tx)
        data_q <= rx_next;                                                                               // RQ14
      else if (wr_d && !busy_q)
        data_q <= wdata;                                                                                 // RQ19
    end
  end

  // Status flags: a hardware set always wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      new_q   <= 1'b0;
      wbr_q   <= 1'b0;
      rbf_q   <= 1'b0;
      write_collision_flag_q  <= 1'b0;
      iflag_q <= 1'b0;
      ien_q   <= 1'b0;
    end
    else
    begin
      if (go)
        new_q <= 1'b0;                                                                                   // RQ10
      else if (wr_d && !busy_q)
        new_q <= 1'b1;
      if (wr_d && !busy_q)
        wbr_q <= rbf_q && !rd_d;                                                                         // RQ15
      if (done && !m_tx)
        rbf_q <= 1'b1;                                                                                   // RQ18
      else if (rd_d)
        rbf_q <= 1'b0;                                                                                   // RQ18
      if (wr_d && busy_q)
        write_collision_flag_q <= 1'b1;                                                                                  // RQ19
      else if (wr_a && !wdata[ssp_pkg::SSP_A_WRITE_COLLISION_FLAG])
        write_collision_flag_q <= 1'b0;
      if (done)
        iflag_q <= 1'b1;                                                                                 // RQ20
      else if (wr_i && !wdata[ssp_pkg::SSP_I_FLAG])
        iflag_q <= 1'b0;
      if (wr_i)
        ien_q <= wdata[ssp_pkg::SSP_I_EN];
    end
  end

  // Shift engine.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_q  <= 8'h00;
      rx_q  <= 8'h00;
      lat_q <= 4'h0;
      hc_q  <= 5'h00;
    end
    else if (go)
    begin
      tx_q  <= tx_src;                                                                                   // RQ7
      lat_q <= 4'h0;
      hc_q  <= 5'h00;
    end
    else
    begin
      if (tick && busy_q)
        hc_q <= hc_q + 5'h01;
      if (latch)
        lat_q <= lat_q + 4'h1;
      if (advance)
        tx_q <= tx_next;                                                                                 // RQ13
      if (sample)
        rx_q <= rx_next;                                                                                 // RQ11
    end
  end

  // Pin drivers and the interrupt request.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_q  <= 1'b1;
      sck_oe <= 1'b0;
      so_o   <= 1'b0;
      so_oe  <= 1'b0;
      irq    <= 1'b0;
      rdata  <= 8'h00;
    end
    else
    begin
      if (!busy_q || hc_q >= ssp_pkg::SSP_HALVES)
        sck_q <= sck_idl;
      else if (i_shift)
        sck_q <= ~sck_idl;                                                                               // RQ2
      else if (i_latch)
        sck_q <= sck_idl;
      sck_oe <= !ext;                                                                                    // RQ2
      so_o   <= busy_q ? tx_bit : (cfg_q.lsb_first ? tx_src[0] : tx_src[7]);
      so_oe  <= !m_rx && !desel;                                                                         // RQ1 RQ17
      irq    <= iflag_q && ien_q;                                                                        // RQ20
      rdata  <= rd ? rd_mux : 8'h00;
    end
  end

  assign sck_o = sck_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_done_clears;
    done |=> !start_q && iflag_q && !busy_q;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("start not cleared or flag not set at end");  // RQ8

  property p_tx_guard;
    go && !ext && m_tx |-> new_q;
  endproperty
  a_tx_guard: assert property (p_tx_guard) else $error("transmit began without fresh data");             // RQ10

  property p_rx_guard;
    go && !ext && m_rx |-> !rbf_q;
  endproperty
  a_rx_guard: assert property (p_rx_guard) else $error("receive began with unread byte");                // RQ12

  property p_dup_guard;
    go && !ext && m_dup |-> !rbf_q && !wbr_q && new_q;
  endproperty
  a_dup_guard: assert property (p_dup_guard) else $error("duplex began after write before read");        // RQ15

  property p_collision;
    wr_d && busy_q && !done |=> write_collision_flag_q && (data_q == $past(data_q));
  endproperty
  a_collision: assert property (p_collision) else $error("write during shift not caught");               // RQ19

  property p_rbf;
    done && !m_tx |=> rbf_q ##1 (rbf_q || $past(rd_d));
  endproperty
  a_rbf: assert property (p_rbf) else $error("receive full flag wrong");                                 // RQ18

  property p_irq_gate;
    !ien_q |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enable");                       // RQ20

  property p_deselect;
    desel [*2] |-> !so_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("output driven while deselected");               // RQ17

  property p_rx_pins;
    m_rx ##1 m_rx |-> !so_oe;
  endproperty
  a_rx_pins: assert property (p_rx_pins) else $error("output driven in receive-only mode");             // RQ1

  property p_one_byte;
    done |=> !busy_q ##1 (!busy_q || $past(start_q));
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("transfer continued without new start");         // RQ9

  c_tx_done:  cover property (done && m_tx);
  c_dup_done: cover property (done && m_dup && !ext);
  c_ext_rx:   cover property (done && m_rx && ext);
  c_collide:  cover property (wr_d && busy_q);
endmodule : ssp_core

// file: core/ssp_pkg.sv
package ssp_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] SSP_OFS_CTRL_A = 8'h05;
  localparam logic [7:0] SSP_OFS_CTRL_B = 8'h06;
  localparam logic [7:0] SSP_OFS_DATA   = 8'h07;
  localparam logic [7:0] SSP_OFS_OPT    = 8'h08;
  localparam logic [7:0] SSP_OFS_IRQ    = 8'h09;

  // Field positions in spi_control_a.
  localparam int SSP_A_SMP  = 7;
  localparam int SSP_A_WRITE_COLLISION_FLAG = 6;
  localparam int SSP_A_RATE = 3;
  localparam int SSP_A_EDGE = 2;
  localparam int SSP_A_ORD  = 1;
  localparam int SSP_A_WBE  = 0;

  // Field positions in spi_control_b.
  localparam int SSP_B_START = 7;
  localparam int SSP_B_MODE  = 1;
  localparam int SSP_B_RBF   = 0;

  // Field positions in the option and interrupt registers.
  localparam int SSP_O_EXTCLK = 0;
  localparam int SSP_O_SSEN   = 1;
  localparam int SSP_I_FLAG   = 0;
  localparam int SSP_I_EN     = 1;

  localparam logic [7:0] SSP_RST_REG = 8'h00;

  // Bits per transfer and serial-clock half periods per transfer.
  localparam int         SSP_BITS  = 8;
  localparam logic [4:0] SSP_HALVES = 5'h10;

  // Half period of each internal serial clock, in clk cycles.
  localparam logic [7:0] SSP_HALF_0 = 8'h04;
  localparam logic [7:0] SSP_HALF_1 = 8'h08;
  localparam logic [7:0] SSP_HALF_2 = 8'h10;
  localparam logic [7:0] SSP_HALF_3 = 8'h20;
  localparam logic [7:0] SSP_HALF_4 = 8'h40;
  localparam logic [7:0] SSP_HALF_5 = 8'h80;

  typedef enum logic [1:0] {
    SSP_MODE_TX   = 2'h0,
    SSP_MODE_RX   = 2'h1,
    SSP_MODE_TXRX = 2'h2,
    SSP_MODE_RSV  = 2'h3
  } ssp_mode_t;

  typedef struct packed {
    logic sck;
    logic si;
    logic ss;
  } ssp_pins_t;

  typedef struct packed {
    logic       sample_phase_select;
    logic [2:0] rate;
    logic       edge_sel;
    logic       lsb_first;
    ssp_mode_t  mode;
    logic       ext_clk;
    logic       ss_en;
  } ssp_cfg_t;

endpackage : ssp_pkg

// file: core/ssp_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a level is taken once stages two and three agree.
module ssp_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] prev_q;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        s1_q[i]    <= 1'b0;
        s2_q[i]    <= 1'b0;
        s3_q[i]    <= 1'b0;
        level_q[i] <= 1'b0;
        prev_q[i]  <= 1'b0;
      end
      else
      begin
        s1_q[i]   <= pin_i[i];
        s2_q[i]   <= s1_q[i];
        s3_q[i]   <= s2_q[i];
        prev_q[i] <= level_q[i];
        if (s2_q[i] == s3_q[i])
          level_q[i] <= s3_q[i];
      end
    end
    assign rise[i] = level_q[i] & ~prev_q[i];
    assign fall[i] = ~level_q[i] & prev_q[i];
  end
endmodule : ssp_sync

// file: core/ssp_rate_gen.sv
`timescale 1ns/1ps
// Pulses once per serial-clock half period while enabled.
module ssp_rate_gen (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       en,
  input  wire logic [2:0] rate,
  output logic            tick
);
  logic [7:0] cnt_q;
  logic [7:0] half;

  // Codes six and seven fall back to the slowest rate.
  assign half = (rate == 3'h0) ? ssp_pkg::SSP_HALF_0 :
                (rate == 3'h1) ? ssp_pkg::SSP_HALF_1 :
                (rate == 3'h2) ? ssp_pkg::SSP_HALF_2 :
                (rate == 3'h3) ? ssp_pkg::SSP_HALF_3 :
                (rate == 3'h4) ? ssp_pkg::SSP_HALF_4 : ssp_pkg::SSP_HALF_5;
  assign tick = en && (cnt_q == half - 8'h01);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 8'h00;
    else if (!en || tick)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule : ssp_rate_gen

// file: sim/ssp_far_dev.sv
`timescale 1ns/1ps
// Far-side serial device: a slave on the port's own clock, a clocking master when ext is high.
module ssp_far_dev (
  input  wire logic       ext,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic       edge_sel,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sck_pin,
  input  wire logic       so_pin,
  output logic            sck_drv,
  output logic            si_o,
  output logic            ss_n,
  output logic      [7:0] rx_byte
);
  wire act = sel | ~ss_n;
  int  cnt;

  function automatic logic pick(input int k);
    return lsb_first ? tx_byte[k] : tx_byte[7-k];
  endfunction : pick

  initial
  begin
    sck_drv = 1'b1;
    si_o = 1'b0;
    ss_n = 1'b1;
    rx_byte = 8'h00;
    cnt = 0;
  end

  always @(posedge act)
  begin
    cnt = 0;
    si_o = pick(0);
  end

  // A released line shows the inverse of its last bit, so a stale value never passes for data.
  always @(negedge act) si_o = ~si_o;

  always @(sck_pin)
  begin
    if (act && sck_pin === ~edge_sel && cnt < 8)
    begin
      rx_byte = lsb_first ? {so_pin, rx_byte[7:1]} : {rx_byte[6:0], so_pin};
      cnt = cnt + 1;
    end
    else if (act && sck_pin === edge_sel && cnt > 0 && cnt < 8)
      si_o = pick(cnt);
  end

  // The clock stands still outside a frame; select frames it with margin on both sides.
  // Offsets keep every pin change off the port's sampling edges.
  always @(posedge go)
  begin
    if (ext)
    begin
      #1;
      ss_n = 1'b0;
      #200.25;
      repeat (8)
      begin
        sck_drv = edge_sel;
        #62.5;
        sck_drv = ~edge_sel;
        #62.5;
      end
      #100;
      ss_n = 1'b1;
    end
  end
endmodule : ssp_far_dev

// file: sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb;
  logic       clk, nrst, wr, rd, rd_d;
  logic [7:0] addr, wdata, rdata, m_e, m_m;
  logic       sck_o, sck_oe, so_o, so_oe, irq;
  logic       p_ext, p_go, p_sel, p_edge, p_lsb;
  logic [7:0] p_byte, p_rx, last_rx;
  wire        sck_drv, si_pin, ss_n, sck_pin, so_pin;
  logic [7:0] exp_q[$], msk_q[$];
  string      name_q[$], m_n;
  int         fail_count, compares, seed;

  assign sck_pin = sck_oe ? sck_o : sck_drv;
  // An undriven output toggles every half cycle so that nothing settles on a lucky value.
  assign so_pin = so_oe ? so_o : clk;

  ssp_core u_dut (
    .clk    (clk),
    .nrst   (nrst),
    .addr   (addr),
    .wdata  (wdata),
    .wr     (wr),
    .rd     (rd),
    .rdata  (rdata),
    .sck_i  (sck_pin),
    .sck_o  (sck_o),
    .sck_oe (sck_oe),
    .si_i   (si_pin),
    .so_o   (so_o),
    .so_oe  (so_oe),
    .ss_n_i (ss_n),
    .irq    (irq)
  );

  ssp_far_dev u_far (
    .ext       (p_ext),
    .go        (p_go),
    .sel       (p_sel),
    .edge_sel  (p_edge),
    .lsb_first (p_lsb),
    .tx_byte   (p_byte),
    .sck_pin   (sck_pin),
    .so_pin    (so_pin),
    .sck_drv   (sck_drv),
    .si_o      (si_pin),
    .ss_n      (ss_n),
    .rx_byte   (p_rx)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
    begin
      m_e = exp_q.pop_front();
      m_m = msk_q.pop_front();
      m_n = name_q.pop_front();
      `CHK(m_n, m_e, rdata & m_m)
    end
    rd_d <= rd;
  end

  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    name_q.push_back(n);
    @(posedge clk);
  endtask : rd_exp

  task automatic wait_irq();
    idle(1);
    for (int n = 0; n < 5000; n++)
    begin
      if (irq === 1'b1)
        return;
      @(posedge clk);
    end
    fail_count++;
    $display("[FAIL] irq expected 1 seen %b", irq);
    stop_test();
  endtask : wait_irq

  // One byte per start; hold keeps a guard closed first, keep leaves the received byte unread.
  task automatic xfer(input logic [1:0] m, input logic [7:0] ca, input logic [7:0] d, input bit hold, input bit keep);
    logic [7:0] cb;
    cb = {1'b1, 4'h0, m, 1'b0};
    p_byte = 8'($random(seed));
    p_edge = ca[ssp_pkg::SSP_A_EDGE];
    p_lsb = ca[ssp_pkg::SSP_A_ORD];
    wr_reg(ssp_pkg::SSP_OFS_CTRL_A, ca);
    if (m != 2'h1 && (m == 2'h2 || !hold))
      wr_reg(ssp_pkg::SSP_OFS_DATA, d);
    idle(2);
    p_sel = !p_ext;
    wr_reg(ssp_pkg::SSP_OFS_CTRL_B, cb);
    p_go = p_ext;
    if (hold)
    begin
      idle(400);
      `CHK("withheld_irq", 1'b0, irq)
      rd_exp(ssp_pkg::SSP_OFS_CTRL_B, cb, 8'hfe, "start_pending");
      if (m != 2'h0)
        rd_exp(ssp_pkg::SSP_OFS_DATA, (m == 2'h2) ? d : last_rx, 8'hff, "rx_before_write");
      if (m != 2'h1)
        wr_reg(ssp_pkg::SSP_OFS_DATA, d);
    end
    if (m == 2'h0 && !hold)
    begin
      idle(6);
      wr_reg(ssp_pkg::SSP_OFS_DATA, ~d);
    end
    wait_irq();
    idle(20);
    `CHK("irq_level", 1'b1, irq)
    `CHK("sck_drive", !p_ext, sck_oe)
    if (m != 2'h1)
      `CHK("far_rx", d, p_rx)
    rd_exp(ssp_pkg::SSP_OFS_IRQ, 8'h03, 8'h03, "irq_reg");
    rd_exp(ssp_pkg::SSP_OFS_CTRL_B, {5'h00, m, m != 2'h0}, 8'hff, "ctrl_b_done");
    if (m == 2'h0 && !hold)
      rd_exp(ssp_pkg::SSP_OFS_CTRL_A, 8'h40, 8'h40, "collision");
    if (m != 2'h0 && !keep)
    begin
      rd_exp(ssp_pkg::SSP_OFS_DATA, p_byte, 8'hff, "rx_data");
      rd_exp(ssp_pkg::SSP_OFS_CTRL_B, {5'h00, m, 1'b0}, 8'hff, "rbf_clear");
    end
    last_rx = p_byte;
    p_sel = 1'b0;
    p_go = 1'b0;
    wr_reg(ssp_pkg::SSP_OFS_IRQ, 8'h02);
    idle(3);
    `CHK("irq_clear", 1'b0, irq)
  endtask : xfer

  initial
  begin
    seed = 88393;
    {addr, wdata, wr, rd, nrst} = '0;
    {p_ext, p_go, p_sel, p_edge, p_lsb} = '0;
    p_byte = 8'h00;
    last_rx = 8'h00;
    fail_count = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 5; a < 11; a++)
      rd_exp(8'(a), (a == 5) ? 8'h01 : 8'h00, 8'hff, "reset_value");
    wr_reg(8'h0a, 8'h5a);
    rd_exp(8'h0a, 8'h00, 8'hff, "unmapped");
    wr_reg(ssp_pkg::SSP_OFS_IRQ, 8'h02);
    idle(2);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
      xfer(2'(i % 3), {i[2], 1'b0, 3'(i), i[1], i[0], 1'b0}, 8'($random(seed)), 1'b0, 1'b0);
    $display("test rates done");
    xfer(2'h0, 8'h08, 8'ha5, 1'b1, 1'b0);
    xfer(2'h1, 8'h08, 8'h00, 1'b0, 1'b1);
    xfer(2'h1, 8'h0a, 8'h00, 1'b1, 1'b0);
    xfer(2'h2, 8'h08, 8'h3c, 1'b0, 1'b1);
    xfer(2'h2, 8'h0c, 8'hc3, 1'b1, 1'b0);
    $display("test guards done");
    p_ext = 1'b1;
    wr_reg(ssp_pkg::SSP_OFS_OPT, 8'h03);
    xfer(2'h2, 8'h00, 8'($random(seed)), 1'b0, 1'b0);
    idle(40);
    `CHK("so_release", 1'b0, so_oe)
    $display("test external done");
    stop_test();
  end
endmodule : tb
